/* hdl/smrb_consts.vh */
`ifndef SMRB_CONSTS_VH
`define SMRB_CONSTS_VH

// Register addresses
`define SMRB_ADDR_DC_CTRL      10'h10C
`define SMRB_ADDR_DC_A_LO      10'h10D
`define SMRB_ADDR_DC_A_HI      10'h10E
`define SMRB_ADDR_DC_B_LO      10'h10F
`define SMRB_ADDR_DC_B_HI      10'h110
`define SMRB_ADDR_SER_CTRL     10'h111
`define SMRB_ADDR_MON_CTRL     10'h112
`define SMRB_ADDR_PERIOD0      10'h113
`define SMRB_ADDR_PERIOD1      10'h114
`define SMRB_ADDR_PERIOD2      10'h115
`define SMRB_ADDR_RES_A0       10'h116
`define SMRB_ADDR_RES_A1       10'h117
`define SMRB_ADDR_RES_A2       10'h118
`define SMRB_ADDR_RES_B0       10'h119
`define SMRB_ADDR_RES_B1       10'h11A
`define SMRB_ADDR_RES_B2       10'h11B

// Reset values and minimum period
`define SMRB_RST_DC_CTRL       8'h00
`define SMRB_RST_SER_CTRL      8'h04
`define SMRB_RST_MON_CTRL      8'h00
`define SMRB_RST_PERIOD        24'h000040
`define SMRB_MIN_PERIOD        24'h000080

// Writable bit masks (open bits read zero)
`define SMRB_MASK_DC_CTRL      8'h7F
`define SMRB_MASK_SER_CTRL     8'h7F
`define SMRB_MASK_MON_CTRL     8'h8F

// dc_correction_control fields
`define SMRB_DC_FREEZE_BIT     6
`define SMRB_DC_BW_MSB         5
`define SMRB_DC_BW_LSB         2
`define SMRB_DC_PATH_EN_BIT    1
`define SMRB_DC_MON_EN_BIT     0

// monitor_serial_out_control fields
`define SMRB_SER_MAG_EN_BIT    6
`define SMRB_SER_PEAK_EN_BIT   5
`define SMRB_SER_THR_EN_BIT    4
`define SMRB_SER_DIV_MSB       3
`define SMRB_SER_DIV_LSB       2
`define SMRB_SER_SLEEP_BIT     1
`define SMRB_SER_EN_BIT        0

// monitor_control fields
`define SMRB_MON_CPLX_BIT      7
`define SMRB_MON_MS_BIT        3
`define SMRB_MON_MODE_MSB      2
`define SMRB_MON_MODE_LSB      1
`define SMRB_MON_EN_BIT        0

// Monitor mode codes
`define SMRB_MODE_MAG          2'h0
`define SMRB_MODE_PEAK         2'h1

// Serial clock divide codes and ratios
`define SMRB_DIV_CODE_2        2'h1
`define SMRB_DIV_CODE_4        2'h2
`define SMRB_DIV_CODE_8        2'h3
`define SMRB_DIV_RATIO_2       4'h2
`define SMRB_DIV_RATIO_4       4'h4
`define SMRB_DIV_RATIO_8       4'h8
`define SMRB_DIV_RATIO_NONE    4'h0

`endif

/* hdl/smrb_period_timer.v */
`include "smrb_consts.vh"

module smrb_period_timer #(
    parameter PERIOD_WIDTH = 24
) (
    // Clock and reset
    input  wire                    ref_clk,
    input  wire                    rst,
    // Control
    input  wire                    enable,
    input  wire [PERIOD_WIDTH-1:0] period,
    // Result
    output reg                     periodEnd
);
    reg [PERIOD_WIDTH-1:0] count_q;
    wire                   lastCycle;

    // Period of 0 or 1 ends every cycle rather than locking up
    assign lastCycle = (count_q + {{(PERIOD_WIDTH-1){1'b0}}, 1'b1}) >= period;

    always @(posedge ref_clk) begin
        if (rst || !enable) begin
            count_q   <= {PERIOD_WIDTH{1'b0}};
            periodEnd <= 1'b0;
        end else if (lastCycle) begin
            count_q   <= {PERIOD_WIDTH{1'b0}};
            periodEnd <= 1'b1; // [RULE8]
        end else begin
            count_q   <= count_q + {{(PERIOD_WIDTH-1){1'b0}}, 1'b1};
            periodEnd <= 1'b0;
        end
    end
endmodule

/* hdl/smrb_register_bank.v */
// Function
// [RULE1] Mode 00 reports rms/ms magnitude, 01 peak power, 1x threshold count.
// [RULE2] Channel A 20-bit read-only result over three bytes, upper bits zero.
// [RULE3] Channel B independent 20-bit read-only result, writes have no effect.
// [RULE4] Path correction bit subtracts dc estimate from sample stream; 4-bit bandwidth.
// [RULE5] Monitor correction bit applies dc estimate only inside the measurement.
// [RULE6] Serial clock divide code 01 by 2, 10 by 4, 11 by 8.
// [RULE7] Power select bit low gives rms, high gives mean-square.
// [RULE8] 24-bit period in converter cycles, resets to 64, program at least 128.
// [RULE9] Freeze bit holds the last dc estimate used by the monitor.
// [RULE10] Each completed period loads new results, replacing the previous ones.
`include "smrb_consts.vh"

module smrb_register_bank #(
    parameter ADDR_WIDTH   = 10,
    parameter DATA_WIDTH   = 14,
    parameter RES_WIDTH    = 20,
    parameter PERIOD_WIDTH = 24
) (
    // Clock and reset
    input  wire                    ref_clk,
    input  wire                    rst,
    // Register port from the serial control interface
    input  wire [ADDR_WIDTH-1:0]   regAddr,
    input  wire                    regWrite,
    input  wire [7:0]              regWrData,
    output reg  [7:0]              regRdData,
    // Sample streams, twos complement
    input  wire                    sampleValid,
    input  wire [DATA_WIDTH-1:0]   sampleA,
    input  wire [DATA_WIDTH-1:0]   sampleB,
    output reg  [DATA_WIDTH-1:0]   pathSampleA,
    output reg  [DATA_WIDTH-1:0]   pathSampleB,
    // Dc estimates from the averaging engine
    input  wire [DATA_WIDTH-1:0]   dcEstA,
    input  wire [DATA_WIDTH-1:0]   dcEstB,
    // Measurement values from the arithmetic engine
    input  wire [RES_WIDTH-1:0]    magA,
    input  wire [RES_WIDTH-1:0]    magB,
    input  wire [RES_WIDTH-1:0]    peakA,
    input  wire [RES_WIDTH-1:0]    peakB,
    input  wire [RES_WIDTH-1:0]    thrCountA,
    input  wire [RES_WIDTH-1:0]    thrCountB,
    // Controls to the monitor engine
    output wire                    monitorEnable,
    output wire                    meanSquareSel,
    output wire                    complexPowerEn,
    output wire [3:0]              dcBandwidth,
    output reg  [DATA_WIDTH-1:0]   monDcA,
    output reg  [DATA_WIDTH-1:0]   monDcB,
    output wire                    periodDone,
    // Controls to the monitor serial output port
    output wire                    serOutEnable,
    output wire                    serClkSleep,
    output wire                    serMagEnable,
    output wire                    serPeakEnable,
    output wire                    serThrEnable,
    output reg  [3:0]              serClkDivRatio
);
    reg  [7:0]              dcCtrl_q;
    reg  [7:0]              serCtrl_q;
    reg  [7:0]              monCtrl_q;
    reg  [PERIOD_WIDTH-1:0] period_q;
    reg  [DATA_WIDTH-1:0]   dcHeldA_q;
    reg  [DATA_WIDTH-1:0]   dcHeldB_q;
    reg  [RES_WIDTH-1:0]    resA_q;
    reg  [RES_WIDTH-1:0]    resB_q;
    wire [1:0]              monMode;
    wire                    dcFreeze;
    wire                    dcPathEn;
    wire                    dcMonEn;

    assign dcFreeze       = dcCtrl_q[`SMRB_DC_FREEZE_BIT];
    assign dcPathEn       = dcCtrl_q[`SMRB_DC_PATH_EN_BIT];
    assign dcMonEn        = dcCtrl_q[`SMRB_DC_MON_EN_BIT];
    assign dcBandwidth    = dcCtrl_q[`SMRB_DC_BW_MSB:`SMRB_DC_BW_LSB]; // [RULE4]
    assign monMode        = monCtrl_q[`SMRB_MON_MODE_MSB:`SMRB_MON_MODE_LSB];
    assign monitorEnable  = monCtrl_q[`SMRB_MON_EN_BIT];
    assign meanSquareSel  = monCtrl_q[`SMRB_MON_MS_BIT]; // [RULE7]
    assign complexPowerEn = monCtrl_q[`SMRB_MON_CPLX_BIT];
    assign serOutEnable   = serCtrl_q[`SMRB_SER_EN_BIT];
    assign serClkSleep    = serCtrl_q[`SMRB_SER_SLEEP_BIT];
    assign serMagEnable   = serCtrl_q[`SMRB_SER_MAG_EN_BIT];
    assign serPeakEnable  = serCtrl_q[`SMRB_SER_PEAK_EN_BIT];
    assign serThrEnable   = serCtrl_q[`SMRB_SER_THR_EN_BIT];

    // Selects the measurement that the result registers report
    function [RES_WIDTH-1:0] selectResult;
        input [1:0]           mode;
        input [RES_WIDTH-1:0] mag;
        input [RES_WIDTH-1:0] peak;
        input [RES_WIDTH-1:0] thr;
        begin
            if (mode == `SMRB_MODE_MAG)
                selectResult = mag; // [RULE1]
            else if (mode == `SMRB_MODE_PEAK)
                selectResult = peak; // [RULE1]
            else
                selectResult = thr; // [RULE1]
        end
    endfunction

    // Code 00 is undefined; report ratio 0 so the serial port can hold its clock
    always @* begin
        case (serCtrl_q[`SMRB_SER_DIV_MSB:`SMRB_SER_DIV_LSB])
            `SMRB_DIV_CODE_2: serClkDivRatio = `SMRB_DIV_RATIO_2; // [RULE6]
            `SMRB_DIV_CODE_4: serClkDivRatio = `SMRB_DIV_RATIO_4; // [RULE6]
            `SMRB_DIV_CODE_8: serClkDivRatio = `SMRB_DIV_RATIO_8; // [RULE6]
            default:          serClkDivRatio = `SMRB_DIV_RATIO_NONE;
        endcase
    end

    // Writable registers; read-only addresses ignore writes
    always @(posedge ref_clk) begin
        if (rst) begin
            dcCtrl_q  <= `SMRB_RST_DC_CTRL;
            serCtrl_q <= `SMRB_RST_SER_CTRL;
            monCtrl_q <= `SMRB_RST_MON_CTRL;
            period_q  <= `SMRB_RST_PERIOD; // [RULE8]
        end else if (regWrite) begin
            if (regAddr == `SMRB_ADDR_DC_CTRL)
                dcCtrl_q <= regWrData & `SMRB_MASK_DC_CTRL;
            else if (regAddr == `SMRB_ADDR_SER_CTRL)
                serCtrl_q <= regWrData & `SMRB_MASK_SER_CTRL;
            else if (regAddr == `SMRB_ADDR_MON_CTRL)
                monCtrl_q <= regWrData & `SMRB_MASK_MON_CTRL;
            else if (regAddr == `SMRB_ADDR_PERIOD0)
                period_q[7:0] <= regWrData;
            else if (regAddr == `SMRB_ADDR_PERIOD1)
                period_q[15:8] <= regWrData;
            else if (regAddr == `SMRB_ADDR_PERIOD2)
                period_q[23:16] <= regWrData;
        end
    end

    // Dc estimate as seen by the monitor and the readback registers
    always @(posedge ref_clk) begin
        if (rst) begin
            dcHeldA_q <= {DATA_WIDTH{1'b0}};
            dcHeldB_q <= {DATA_WIDTH{1'b0}};
        end else if (!dcFreeze) begin // [RULE9]
            dcHeldA_q <= dcEstA;
            dcHeldB_q <= dcEstB;
        end
    end

    // Monitor correction is separate from path correction
    always @(posedge ref_clk) begin
        if (rst) begin
            monDcA <= {DATA_WIDTH{1'b0}};
            monDcB <= {DATA_WIDTH{1'b0}};
        end else begin
            monDcA <= dcMonEn ? dcHeldA_q : {DATA_WIDTH{1'b0}}; // [RULE5]
            monDcB <= dcMonEn ? dcHeldB_q : {DATA_WIDTH{1'b0}}; // [RULE5]
        end
    end

    // Path correction uses the live estimate, so freezing only affects the monitor and the dc readback registers
    always @(posedge ref_clk) begin
        if (rst) begin
            pathSampleA <= {DATA_WIDTH{1'b0}};
            pathSampleB <= {DATA_WIDTH{1'b0}};
        end else if (sampleValid) begin
            pathSampleA <= dcPathEn ? sampleA - dcEstA : sampleA; // [RULE4]
            pathSampleB <= dcPathEn ? sampleB - dcEstB : sampleB; // [RULE4]
        end
    end

    smrb_period_timer #(
        .PERIOD_WIDTH (PERIOD_WIDTH)
    ) periodTimer (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .enable    (monitorEnable),
        .period    (period_q),
        .periodEnd (periodDone)
    );

    always @(posedge ref_clk) begin
        if (rst) begin
            resA_q <= {RES_WIDTH{1'b0}};
            resB_q <= {RES_WIDTH{1'b0}};
        end else if (periodDone) begin // [RULE10]
            resA_q <= selectResult(monMode, magA, peakA, thrCountA); // [RULE2]
            resB_q <= selectResult(monMode, magB, peakB, thrCountB); // [RULE3]
        end
    end

    // Registered read data; unmapped addresses read zero
    always @(posedge ref_clk) begin
        if (rst)
            regRdData <= 8'h00;
        else if (regAddr == `SMRB_ADDR_DC_CTRL)
            regRdData <= dcCtrl_q;
        else if (regAddr == `SMRB_ADDR_DC_A_LO)
            regRdData <= dcHeldA_q[7:0];
        else if (regAddr == `SMRB_ADDR_DC_A_HI)
            regRdData <= {2'h0, dcHeldA_q[13:8]};
        else if (regAddr == `SMRB_ADDR_DC_B_LO)
            regRdData <= dcHeldB_q[7:0];
        else if (regAddr == `SMRB_ADDR_DC_B_HI)
            regRdData <= {2'h0, dcHeldB_q[13:8]};
        else if (regAddr == `SMRB_ADDR_SER_CTRL)
            regRdData <= serCtrl_q;
        else if (regAddr == `SMRB_ADDR_MON_CTRL)
            regRdData <= monCtrl_q;
        else if (regAddr == `SMRB_ADDR_PERIOD0)
            regRdData <= period_q[7:0];
        else if (regAddr == `SMRB_ADDR_PERIOD1)
            regRdData <= period_q[15:8];
        else if (regAddr == `SMRB_ADDR_PERIOD2)
            regRdData <= period_q[23:16];
        else if (regAddr == `SMRB_ADDR_RES_A0)
            regRdData <= resA_q[7:0]; // [RULE2]
        else if (regAddr == `SMRB_ADDR_RES_A1)
            regRdData <= resA_q[15:8]; // [RULE2]
        else if (regAddr == `SMRB_ADDR_RES_A2)
            regRdData <= {4'h0, resA_q[19:16]}; // [RULE2]
        else if (regAddr == `SMRB_ADDR_RES_B0)
            regRdData <= resB_q[7:0]; // [RULE3]
        else if (regAddr == `SMRB_ADDR_RES_B1)
            regRdData <= resB_q[15:8]; // [RULE3]
        else if (regAddr == `SMRB_ADDR_RES_B2)
            regRdData <= {4'h0, resB_q[19:16]}; // [RULE3]
        else
            regRdData <= 8'h00;
    end
endmodule

/* test/smrb_register_bank_asserts.sv */
module smrb_register_bank_asserts #(
    parameter ADDR_WIDTH = 10
) (
    input wire                  ref_clk,
    input wire                  rst,
    input wire [ADDR_WIDTH-1:0] regAddr,
    input wire                  regWrite,
    input wire [7:0]            regWrData,
    input wire [7:0]            regRdData,
    input wire                  monitorEnable,
    input wire                  meanSquareSel,
    input wire [3:0]            dcBandwidth,
    input wire                  periodDone,
    input wire [3:0]            serClkDivRatio
);
    timeunit 1ns;
    timeprecision 1ps;
    // Write data of the previous edge, so a property can see what was written
    reg [7:0] wrData_q;
    always @(posedge ref_clk) wrData_q <= regWrData;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence wr_ser_s; regWrite && regAddr == 10'h111; endsequence
    sequence wr_mon_s; regWrite && regAddr == 10'h112; endsequence
    sequence wr_dc_s; regWrite && regAddr == 10'h10C; endsequence
    div_ratio_a: assert property (wr_ser_s |=>
        serClkDivRatio == ((wrData_q[3:2] == 2'h0) ? 4'h0 : 4'h1 << wrData_q[3:2]))
        else $error("serial clock ratio wrong after write");
    ms_select_a: assert property (wr_mon_s |=>
        meanSquareSel == wrData_q[3] && monitorEnable == wrData_q[0])
        else $error("monitor control outputs wrong after write");
    dc_bandwidth_a: assert property (wr_dc_s |=> dcBandwidth == wrData_q[5:2])
        else $error("dc bandwidth wrong after write");
    res_a_top_a: assert property (regAddr == 10'h118 |=> regRdData[7:4] == 4'h0)
        else $error("channel A result upper bits not zero");
    res_b_top_a: assert property (regAddr == 10'h11B |=> regRdData[7:4] == 4'h0)
        else $error("channel B result upper bits not zero");
    dc_high_a: assert property ((regAddr == 10'h10E || regAddr == 10'h110) |=>
        regRdData[7:6] == 2'h0)
        else $error("dc value upper bits not zero");
    period_idle_a: assert property (!monitorEnable [*2] |-> !periodDone)
        else $error("period end while monitor disabled");
    reset_value_a: assert property ($fell(rst) |->
        serClkDivRatio == 4'h2 && !monitorEnable)
        else $error("wrong values after reset");
endmodule

bind smrb_register_bank smrb_register_bank_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) smrb_asserts_inst (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
    .regWrData(regWrData), .regRdData(regRdData), .monitorEnable(monitorEnable),
    .meanSquareSel(meanSquareSel), .dcBandwidth(dcBandwidth), .periodDone(periodDone),
    .serClkDivRatio(serClkDivRatio)
);

/* test/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [9:0]  regAddr = 10'h000;
    logic        regWrite = 1'b0;
    logic [7:0]  regWrData = 8'h00;
    logic        sampleValid = 1'b0;
    logic [13:0] sampleA = 14'h0000;
    logic [13:0] sampleB = 14'h0000;
    logic [13:0] dcEstA = 14'h0000;
    logic [13:0] dcEstB = 14'h0000;
    logic [19:0] meas [6] = '{default: 20'h00000};
    logic [7:0]  regRdData, b, d;
    logic [13:0] pathSampleA, pathSampleB, monDcA, monDcB, saved;
    logic [3:0]  dcBandwidth, serClkDivRatio;
    logic        monitorEnable, meanSquareSel, complexPowerEn, periodDone;
    logic        serOutEnable, serClkSleep, serMagEnable, serPeakEnable, serThrEnable;
    logic [23:0] va, vb;
    int          failCount = 0;
    int          compares = 0;
    int          cycles = 0;
    int          n;
    always #20 ref_clk = ~ref_clk;
    smrb_register_bank smrb_register_bank_inst (
        .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
        .regWrData(regWrData), .regRdData(regRdData), .sampleValid(sampleValid),
        .sampleA(sampleA), .sampleB(sampleB), .pathSampleA(pathSampleA),
        .pathSampleB(pathSampleB), .dcEstA(dcEstA), .dcEstB(dcEstB),
        .magA(meas[0]), .magB(meas[1]), .peakA(meas[2]), .peakB(meas[3]),
        .thrCountA(meas[4]), .thrCountB(meas[5]), .monitorEnable(monitorEnable),
        .meanSquareSel(meanSquareSel), .complexPowerEn(complexPowerEn),
        .dcBandwidth(dcBandwidth), .monDcA(monDcA), .monDcB(monDcB),
        .periodDone(periodDone), .serOutEnable(serOutEnable), .serClkSleep(serClkSleep),
        .serMagEnable(serMagEnable), .serPeakEnable(serPeakEnable),
        .serThrEnable(serThrEnable), .serClkDivRatio(serClkDivRatio)
    );
    function automatic logic [19:0] pick(input logic [1:0] m, input logic [19:0] g, p, t);
        return (m == 2'h0) ? g : (m == 2'h1) ? p : t;
    endfunction
    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            failCount++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // One idle edge after each write, so back-to-back writes never drop and raise the strobe at once
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        regAddr = a;
        regWrData = v;
        regWrite = 1'b1;
        tick();
        regWrite = 1'b0;
        tick();
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] v);
        regAddr = a;
        tick();
        v = regRdData;
    endtask
    task automatic rdRes(input logic [9:0] a, output logic [23:0] v);
        logic [7:0] x;
        for (int k = 0; k < 3; k++) begin
            rd(a + 10'(k), x);
            v[8*k +: 8] = x;
        end
    endtask
    // Bounded wait for the period end, then one edge so the results have landed
    task automatic waitDone(output int c);
        c = 0;
        while (periodDone !== 1'b1 && c < 300) begin
            tick();
            c++;
        end
        tick();
    endtask
    task automatic endOfTest;
        $display("comparisons %0d, mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failCount++;
            endOfTest();
        end
    end
    initial begin
        void'($urandom(32'hB8DECFF3));
        repeat (2) @(posedge ref_clk);
        #1 rst = 1'b0;
        for (int k = 0; k < 16; k++) begin
            rd(10'h10C + 10'(k), b);
            check(b, (k == 5) ? 8'h04 : (k == 7) ? 8'h40 : 8'h00);
        end
        check(serClkDivRatio, 4'h2);
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            d[3:2] = i[1:0];
            wr(10'h111, d);
            rd(10'h111, b);
            check(b, d & 8'h7F);
            check(serClkDivRatio, (i[1:0] == 2'h0) ? 4'h0 : 4'h1 << i[1:0]);
            check({serMagEnable, serPeakEnable, serThrEnable, serClkSleep, serOutEnable},
                  {d[6:4], d[1:0]});
            d = 8'($urandom);
            wr(10'h112, d);
            rd(10'h112, b);
            check({b, complexPowerEn, meanSquareSel}, {d & 8'h8F, d[7], d[3]});
            d = 8'($urandom);
            wr(10'h10C, d);
            rd(10'h10C, b);
            check({b, dcBandwidth}, {d & 8'h7F, d[5:2]});
            d = 8'($urandom);
            wr(10'h113 + 10'(i % 3), d);
            rd(10'h113 + 10'(i % 3), b);
            check(b, d);
        end
        wr(10'h11C, 8'hA5);
        rd(10'h11C, b);
        check(b, 8'h00);
        $display("register access done");
        // Stop the count first: a random period left behind may be huge
        wr(10'h112, 8'h00);
        wr(10'h113, 8'h80);
        wr(10'h114, 8'h00);
        wr(10'h115, 8'h00);
        for (int m = 0; m < 4; m++) begin
            foreach (meas[j]) meas[j] = 20'($urandom);
            wr(10'h112, {5'h00, m[1:0], 1'b1});
            waitDone(n);
            rdRes(10'h116, va);
            rdRes(10'h119, vb);
            check(va, {4'h0, pick(m[1:0], meas[0], meas[2], meas[4])});
            check(vb, {4'h0, pick(m[1:0], meas[1], meas[3], meas[5])});
            wr(10'h116, 8'h3C);
            wr(10'h11B, 8'h3C);
            rdRes(10'h119, vb);
            check(vb, {4'h0, pick(m[1:0], meas[1], meas[3], meas[5])});
            rd(10'h116, b);
            check(b, va[7:0]);
        end
        waitDone(n);
        waitDone(n);
        check(n, 127);
        $display("monitor results done");
        wr(10'h10C, 8'h02);
        // Strobe held across the loop so it is never lowered and raised in one step
        sampleValid = 1'b1;
        for (int i = 0; i < 6; i++) begin
            sampleA = 14'($urandom);
            sampleB = 14'($urandom);
            dcEstA = 14'($urandom);
            dcEstB = 14'($urandom);
            if (i == 5) wr(10'h10C, 8'h00);
            tick();
            check(pathSampleA, (i == 5) ? sampleA : 14'(sampleA - dcEstA));
            check(pathSampleB, (i == 5) ? sampleB : 14'(sampleB - dcEstB));
        end
        // Without the strobe the corrected samples must hold
        va = 24'(sampleA);
        vb = 24'(sampleB);
        sampleValid = 1'b0;
        sampleA = ~sampleA;
        sampleB = ~sampleB;
        tick();
        check(pathSampleA, va);
        check(pathSampleB, vb);
        $display("path correction done");
        wr(10'h10C, 8'h01);
        repeat (3) tick();
        check({monDcA, monDcB}, {dcEstA, dcEstB});
        rd(10'h10E, b);
        check(b, {2'h0, dcEstA[13:8]});
        wr(10'h10C, 8'h41);
        repeat (3) tick();
        saved = dcEstA;
        dcEstA = ~dcEstA;
        repeat (3) tick();
        check(monDcA, saved);
        wr(10'h10C, 8'h00);
        repeat (3) tick();
        check(monDcA, 14'h0000);
        $display("dc estimate done");
        endOfTest();
    end
endmodule
